// ---- core/drc_pkg.sv ----
// constants, register map and state type of the device reset control
package drc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_IFCFG0 = 6'h00;
  localparam logic [5:0] IDX_IFCFG1 = 6'h01;
  localparam logic [5:0] IDX_PWRDN = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h04;

  // field positions
  localparam int SOFT_RST_BIT = 0;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_PD_BIT = 1;

  // values after reset
  localparam logic [7:0] IFCFG0_RST = 8'h00;
  localparam logic [7:0] IFCFG1_RST = 8'h00;
  localparam logic [7:0] PWRDN_RST = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  localparam int POR_WAIT_US = 250;
  localparam int HW_WAIT_US = 250;
  localparam int HW_LOW_NS = 20;
  localparam int SW_WAIT_NS = 100;
  localparam int POR_WAIT_CYC_DEF =
    (POR_WAIT_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int HW_WAIT_CYC_DEF =
    (HW_WAIT_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int HW_LOW_CYC_RAW =
    (HW_LOW_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int HW_LOW_CYC = (HW_LOW_CYC_RAW < 1) ? 1 : HW_LOW_CYC_RAW;
  localparam int SW_WAIT_CYC_RAW =
    (SW_WAIT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SW_WAIT_CYC = (SW_WAIT_CYC_RAW < 1) ? 1 : SW_WAIT_CYC_RAW;

  // counter widths
  localparam int WAIT_CNT_W = 16;
  localparam int LOW_CNT_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_READY = 2'b11,
    ST_SOFT = 2'b10
  } drc_state_t;

endpackage

// ---- core/drc_top.sv ----
// device reset control: reset sources, post-reset waits, register file
////////////////////////////////////////////////////////////////////////////
module drc_top
  import drc_pkg::*;
#(
  parameter int POR_WAIT_CYC = POR_WAIT_CYC_DEF,
  parameter int HW_WAIT_CYC = HW_WAIT_CYC_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // hardware reset pin
  input wire logic hw_reset_n,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // device status
  output logic [7:0] power_down_control,
  output logic dev_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  drc_state_t state;
  drc_state_t next_state;
  logic pin_meta;
  logic pin_sync;
  logic next_pin_meta;
  logic next_pin_sync;
  logic [LOW_CNT_W-1:0] low_cnt;
  logic [LOW_CNT_W-1:0] next_low_cnt;
  logic hold_req;
  logic timer_load;
  logic [WAIT_CNT_W-1:0] timer_val;
  logic [WAIT_CNT_W-1:0] wait_cnt;
  logic [7:0] interface_config_0;
  logic [7:0] interface_config_1;
  logic [7:0] next_ifcfg0;
  logic [7:0] next_ifcfg1;
  logic [7:0] next_pwrdn;
  logic [31:0] next_readdata;
  logic [31:0] rd_value;
  logic next_waitrequest;
  logic next_dev_ready;
  logic wr_commit;
  logic soft_commit;

  function automatic logic idx_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    idx_hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset pin synchroniser and low-time filter
  always_comb begin
    next_pin_meta = hw_reset_n;
    next_pin_sync = pin_meta;
    next_low_cnt = low_cnt;
    if (pin_sync) begin
      next_low_cnt = '0;
    end else if (low_cnt != {LOW_CNT_W{1'b1}}) begin
      next_low_cnt = low_cnt + 1'b1;
    end
  end

  assign hold_req = !pin_sync &&
    (low_cnt >= LOW_CNT_W'(HW_LOW_CYC - 1));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      low_cnt <= '0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      low_cnt <= next_low_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing
  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_val = WAIT_CNT_W'(SW_WAIT_CYC);
    if (hold_req) begin
      next_state = ST_HOLD;
      timer_load = 1'b1;
      timer_val = WAIT_CNT_W'(HW_WAIT_CYC);
    end else begin
      case (state)
        ST_HOLD: begin
          timer_load = 1'b1;
          timer_val = WAIT_CNT_W'(HW_WAIT_CYC);
          if (pin_sync) begin
            next_state = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_cnt == '0) begin
            next_state = ST_READY;
          end
        end
        ST_READY: begin
          if (soft_commit) begin
            next_state = ST_SOFT;
            timer_load = 1'b1;
            timer_val = WAIT_CNT_W'(SW_WAIT_CYC);
          end
        end
        ST_SOFT: begin
          if (wait_cnt == '0) begin
            next_state = ST_READY;
          end
        end
        default: begin
          next_state = ST_WAIT;
          timer_load = 1'b1;
          timer_val = WAIT_CNT_W'(HW_WAIT_CYC);
        end
      endcase
    end
    next_dev_ready = (next_state == ST_READY);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_WAIT;
      dev_ready <= 1'b0;
    end else begin
      state <= next_state;
      dev_ready <= next_dev_ready;
    end
  end

  drc_wait_timer #(
    .CNT_W(WAIT_CNT_W),
    .RST_VAL(WAIT_CNT_W'(POR_WAIT_CYC))
  ) u_wait_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .load(timer_load),
    .load_val(timer_val),
    .count(wait_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave
  assign wr_commit = write && !waitrequest && byteenable[0];
  assign soft_commit = wr_commit && idx_hit(address, IDX_IFCFG0) &&
    writedata[SOFT_RST_BIT];

  always_comb begin
    rd_value = '0;
    if (idx_hit(address, IDX_IFCFG0)) begin
      rd_value[7:0] = interface_config_0;
    end else if (idx_hit(address, IDX_IFCFG1)) begin
      rd_value[7:0] = interface_config_1;
    end else if (idx_hit(address, IDX_PWRDN)) begin
      rd_value[7:0] = power_down_control;
    end else if (idx_hit(address, IDX_STATUS)) begin
      rd_value[STAT_READY_BIT] = dev_ready;
      rd_value[STAT_PD_BIT] = |power_down_control;
    end
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    if (state == ST_READY && !hold_req && waitrequest &&
        (read ^ write)) begin
      next_waitrequest = 1'b0;
      next_readdata = rd_value;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata <= '0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    next_ifcfg0 = interface_config_0;
    next_ifcfg1 = interface_config_1;
    next_pwrdn = power_down_control;
    if (hold_req || state == ST_HOLD) begin
      next_ifcfg0 = IFCFG0_RST;
      next_ifcfg1 = IFCFG1_RST;
      next_pwrdn = PWRDN_RST;
    end else if (wr_commit) begin
      if (idx_hit(address, IDX_IFCFG0)) begin
        next_ifcfg0 = writedata[7:0];
        next_ifcfg0[SOFT_RST_BIT] = 1'b0;
      end
      if (idx_hit(address, IDX_IFCFG1)) begin
        next_ifcfg1 = writedata[7:0];
      end
      if (idx_hit(address, IDX_PWRDN)) begin
        next_pwrdn = writedata[7:0];
      end
      if (soft_commit) begin
        next_pwrdn = PWRDN_RST;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      interface_config_0 <= IFCFG0_RST;
      interface_config_1 <= IFCFG1_RST;
      power_down_control <= PWRDN_RST;
    end else begin
      interface_config_0 <= next_ifcfg0;
      interface_config_1 <= next_ifcfg1;
      power_down_control <= next_pwrdn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_soft_write;
    write && !waitrequest && byteenable[0] &&
      idx_hit(address, IDX_IFCFG0) && writedata[SOFT_RST_BIT];
  endsequence

  sequence s_soft_run;
    !dev_ready [*3];
  endsequence

  sequence s_release;
    state == ST_HOLD && pin_sync && !hold_req;
  endsequence

  a_hold_entry: assert property (
    hold_req |=> state == ST_HOLD && !dev_ready
  ) else $error("pin reset did not enter hold");

  a_hold_defaults: assert property (
    state == ST_HOLD |-> power_down_control == PWRDN_RST &&
      interface_config_0 == IFCFG0_RST && interface_config_1 == IFCFG1_RST
  ) else $error("registers not default during hold");

  a_pin_release: assert property (
    s_release |=> state == ST_WAIT &&
      wait_cnt == WAIT_CNT_W'(HW_WAIT_CYC)
  ) else $error("release did not start the wait");

  a_wait_ready: assert property (
    state == ST_WAIT && wait_cnt == '0 && !hold_req |=> dev_ready
  ) else $error("wait end did not give ready");

  a_ack_ready: assert property (
    !waitrequest |-> state == ST_READY && $past(dev_ready)
  ) else $error("bus answered while not ready");

  a_soft_start: assert property (
    s_soft_write ##0 !hold_req |=> state == ST_SOFT && !dev_ready
  ) else $error("soft reset bit did not start reset");

  a_soft_keep: assert property (
    s_soft_write ##0 !hold_req |=> power_down_control == PWRDN_RST &&
      interface_config_1 == $past(interface_config_1) &&
      interface_config_0[SOFT_RST_BIT] == 1'b0
  ) else $error("soft reset touched kept registers");

  a_soft_wait: assert property (
    $rose(state == ST_SOFT) |-> s_soft_run ##1 !dev_ready
  ) else $error("soft reset wait too short");

  a_pd_default: assert property (
    $rose(dev_ready) && $past(state) == ST_WAIT |->
      power_down_control == PWRDN_RST
  ) else $error("power-down not default after reset");

  a_status_read: assert property (
    read && !waitrequest && idx_hit(address, IDX_STATUS) |->
      readdata[STAT_READY_BIT] &&
      readdata[STAT_PD_BIT] == (|power_down_control)
  ) else $error("status read wrong");

endmodule

// ---- core/drc_wait_timer.sv ----
// down counter that times the post-reset waits
module drc_wait_timer #(
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // load
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  // state
  output logic [CNT_W-1:0] count
);

  logic [CNT_W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // count down to zero, reload on request
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= RST_VAL;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ---- test/drc_host.sv ----
// host model: avalon-mm master and reset pin driver
module drc_host
  import drc_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // reset pin
  output logic hw_reset_n,
  // avalon-mm master
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // device status
  input wire logic dev_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hw_reset_n = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [3:0] be, input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    byteenable <= be;
    writedata <= {24'h000000, d};
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~{24'h000000, d};
  endtask

  // pin level, changed just after an edge
  task automatic pin(input logic lvl);
    @(posedge sys_clk);
    hw_reset_n <= lvl;
  endtask

  // no traffic until the device is ready again
  task automatic wait_ready(output int n);
    n = 0;
    while (dev_ready !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
endmodule

// ---- test/drc_top_test.sv ----
// testbench of the device reset control
module drc_top_test import drc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PW = 20;
  localparam int HW = 20;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic hw_reset_n;
  logic [7:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] power_down_control;
  logic dev_ready;
  int fails = 0;
  int n_tests = 0;
  int n;
  logic [31:0] seed = 32'h39D4;
  logic [31:0] q;
  logic [7:0] v0, v1, v2;

  always #20 sys_clk = ~sys_clk;

  drc_top #(.POR_WAIT_CYC(PW), .HW_WAIT_CYC(HW)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .hw_reset_n(hw_reset_n),
    .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .power_down_control(power_down_control), .dev_ready(dev_ready));

  drc_host u_host (
    .sys_clk(sys_clk), .hw_reset_n(hw_reset_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .dev_ready(dev_ready));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [31:0] status(input logic [7:0] pd);
    return {30'h0, |pd, 1'b1};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    u_host.bus(1'b0, {idx, 2'b00}, 4'hF, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    u_host.bus(1'b1, {idx, 2'b00}, 4'hF, d, q);
  endtask

  task automatic stop_test;
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    chk({31'h0, dev_ready}, 32'h0);
    chk({24'h0, power_down_control}, 32'hFF);
    u_host.wait_ready(n);
    chk({31'h0, n >= PW && n <= PW + 6}, 32'h1);
    rd(IDX_IFCFG0, 32'h0);
    rd(IDX_IFCFG1, 32'h0);
    rd(IDX_PWRDN, 32'hFF);
    rd(IDX_STATUS, 32'h3);
    rd(6'h03, 32'h0);
    // pin reset with interface_config_1 and power-down away from their defaults
    v1 = rnd() | 8'h01;
    v2 = rnd() & 8'h7F;
    wr(IDX_IFCFG1, v1);
    wr(IDX_PWRDN, v2);
    @(posedge sys_clk);
    chk({24'h0, power_down_control}, {24'h0, v2});
    u_host.pin(1'b0);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, dev_ready}, 32'h0);
    chk({24'h0, power_down_control}, 32'hFF);
    u_host.pin(1'b1);
    u_host.wait_ready(n);
    chk({31'h0, n >= HW && n <= HW + 8}, 32'h1);
    rd(IDX_IFCFG1, 32'h0);
    rd(IDX_PWRDN, 32'hFF);
    // random contents, then software reset
    repeat (4) begin
      v0 = rnd() & 8'hFE;
      v1 = rnd();
      v2 = rnd();
      wr(IDX_IFCFG0, v0);
      wr(IDX_IFCFG1, v1);
      wr(IDX_PWRDN, v2);
      rd(IDX_IFCFG0, {24'h0, v0});
      rd(IDX_STATUS, status(v2));
      wr(IDX_IFCFG0, v0 | 8'h01);
      @(posedge sys_clk);
      chk({31'h0, dev_ready}, 32'h0);
      chk({24'h0, power_down_control}, 32'hFF);
      u_host.wait_ready(n);
      chk({31'h0, n <= 6}, 32'h1);
      rd(IDX_IFCFG0, {24'h0, v0});
      rd(IDX_IFCFG1, {24'h0, v1});
      rd(IDX_PWRDN, 32'hFF);
    end
    // access raised during the hold stalls, lane 0 disabled write ignored
    u_host.pin(1'b0);
    repeat (4) @(posedge sys_clk);
    u_host.pin(1'b1);
    u_host.bus(1'b1, {IDX_PWRDN, 2'b00}, 4'hE, 8'h00, q);
    chk({31'h0, dev_ready}, 32'h1);
    rd(IDX_PWRDN, 32'hFF);
    stop_test();
  end
endmodule
